// [hw/efim_consts.svh]
// Purpose: constants for the event flag and interrupt mask block
// Assumes: 100 MHz ref_clk
// Notes: register offsets are byte addresses on the internal register port
`ifndef EFIM_CONSTS_SVH
`define EFIM_CONSTS_SVH
`define EFIM_FLAGS_OFFSET 8'h00
`define EFIM_MASK_OFFSET 8'h01
`define EFIM_MASK_RESET 8'h00
`define EFIM_FLAGS_RESET 8'h00
`define EFIM_MASK_USED 8'h5f
`define EFIM_BIT_WAKE 6
`define EFIM_BIT_LINE_FAULT 4
`define EFIM_BIT_SUPPLY_WARN 3
`define EFIM_BIT_UNDERVOLT 2
`define EFIM_BIT_SHUTDOWN 1
`define EFIM_BIT_THERM_WARN 0
`define EFIM_CLK_MHZ 100
`define EFIM_WAKE_PULSE_US 200
`define EFIM_WAKE_PULSE_CYC (`EFIM_WAKE_PULSE_US * `EFIM_CLK_MHZ)
`endif

// [hw/efim_pkg.sv]
// Purpose: types for the event flag and interrupt mask block
// Assumes: nothing
// Notes: event carrier order matches flag register bit order
package efim_pkg;
	typedef struct packed {
		logic wake;
		logic line_fault;
		logic supply_warn;
		logic undervolt;
		logic shutdown;
		logic therm_warn;
	} efim_events_type;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} efim_req_type;
	typedef enum logic [1:0] {
		EFIM_PULSE_IDLE = 2'b01,
		EFIM_PULSE_ON = 2'b10
	} efim_pulse_type;
endpackage

// [hw/efim_top.sv]
// Purpose: sticky event flags, mask register and active-low wake/interrupt output
// Assumes: register port driven by the serial engine, one-cycle rd/wr strobes
// Notes: analog comparators deliver synchronous level conditions
`timescale 1ns/10ps
`include "efim_consts.svh"
module efim_top (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// event conditions, levels
	input wire efim_pkg::efim_events_type cond_in,
	// register port
	input wire efim_pkg::efim_req_type req,
	output logic [7:0] rdata,
	output logic rvalid,
	// pin
	output logic wake_alert_out_n
);
	localparam logic [14:0] PULSE_CYC = 15'(`EFIM_WAKE_PULSE_CYC);
	localparam logic [7:0] FLAGS_RST = `EFIM_FLAGS_RESET;
	// flag register bit of each event, in event carrier order from its low end
	localparam int FLAG_POS [6] = '{
		`EFIM_BIT_THERM_WARN,
		`EFIM_BIT_SHUTDOWN,
		`EFIM_BIT_UNDERVOLT,
		`EFIM_BIT_SUPPLY_WARN,
		`EFIM_BIT_LINE_FAULT,
		`EFIM_BIT_WAKE
	};
	efim_pkg::efim_events_type flag_bits;
	efim_pkg::efim_events_type flag_rise;
	logic [7:0] flags_vec;
	logic [7:0] mask_reg;
	logic [14:0] pulse_cnt_reg;
	efim_pkg::efim_pulse_type pulse_state_reg;
	logic flags_rd;
	logic mask_wr;
	logic wake_retrig;
	logic [7:0] irq_src;
	logic irq_level;
	logic [7:0] rd_mux;

	assign flags_rd = req.rd && (req.addr == `EFIM_FLAGS_OFFSET);
	assign mask_wr = req.wr && (req.addr == `EFIM_MASK_OFFSET);

	// one sticky cell per event, all cleared together by a flag register read
	genvar i;
	generate
		for (i = 0; i < 6; i++)
		begin : g_flag
			efim_flag_cell #(
				.RESET_VAL(FLAGS_RST[FLAG_POS[i]])
			) efim_flag_cell_inst (
				.ref_clk(ref_clk),
				.rst(rst),
				.clk_en(clk_en),
				.cond(cond_in[i]),
				.clr(flags_rd),
				.flag(flag_bits[i]),
				.rise(flag_rise[i])
			);
		end
	endgenerate

	// bits 7 and 5 have no event behind them and read as zero
	assign flags_vec = {1'b0, flag_bits.wake, 1'b0, flag_bits[4:0]};

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			mask_reg <= `EFIM_MASK_RESET;
		else if (clk_en && mask_wr)
			mask_reg <= req.wdata & `EFIM_MASK_USED;
	end

	// a new wake edge restarts a running pulse rather than being lost
	assign wake_retrig = flag_rise.wake && mask_reg[`EFIM_BIT_WAKE];

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pulse_state_reg <= efim_pkg::EFIM_PULSE_IDLE;
		else if (clk_en)
		begin
			case (pulse_state_reg)
				efim_pkg::EFIM_PULSE_IDLE:
				begin
					if (wake_retrig)
						pulse_state_reg <= efim_pkg::EFIM_PULSE_ON;
				end
				efim_pkg::EFIM_PULSE_ON:
				begin
					if (!wake_retrig && pulse_cnt_reg == 15'h0000)
						pulse_state_reg <= efim_pkg::EFIM_PULSE_IDLE;
				end
				default:
					pulse_state_reg <= efim_pkg::EFIM_PULSE_IDLE;
			endcase
		end
	end

	// pulse length is fixed by the clock rate; a slower clock stretches it
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pulse_cnt_reg <= 15'h0000;
		else if (clk_en)
		begin
			if (wake_retrig)
				pulse_cnt_reg <= PULSE_CYC - 15'h0001;
			else if (pulse_state_reg == efim_pkg::EFIM_PULSE_ON && pulse_cnt_reg != 15'h0000)
				pulse_cnt_reg <= pulse_cnt_reg - 15'h0001;
		end
	end

	// wake flag with mask 1 uses the pulse, not the level
	always_comb
	begin
		irq_src = flags_vec & ~mask_reg & `EFIM_MASK_USED;
		irq_level = |irq_src;
		if (pulse_state_reg == efim_pkg::EFIM_PULSE_ON)
			irq_level = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			wake_alert_out_n <= 1'b1;
		else if (clk_en)
			wake_alert_out_n <= ~irq_level;
	end

	// flags are read before the same edge clears them
	always_comb
	begin
		case (req.addr)
			`EFIM_FLAGS_OFFSET: rd_mux = flags_vec;
			`EFIM_MASK_OFFSET: rd_mux = mask_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= rd_mux;
		end
	end
endmodule // efim_top

// one sticky event flag: set on a rising condition, cleared by a flag read
module efim_flag_cell #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// condition level and clearing read
	input wire logic cond,
	input wire logic clr,
	// sticky flag and its set strobe
	output logic flag,
	output logic rise
);
	logic cond_reg;

	// rising edge only: a persisting condition does not re-set the flag after a read
	assign rise = cond & ~cond_reg;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cond_reg <= 1'b0;
		else if (clk_en)
			cond_reg <= cond;
	end

	// set wins over the clearing read so no event is lost
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			flag <= RESET_VAL;
		else if (clk_en)
		begin
			if (rise)
				flag <= 1'b1;
			else if (clr)
				flag <= 1'b0;
		end
	end
endmodule // efim_flag_cell

// [bench/efim_top_assertions.sv]
// Purpose: port-level checks of the event flag block
// Assumes: one-cycle read and write strobes
// Notes: mask contents are not visible here, so pin checks stay mask-free
`timescale 1ns/10ps
module efim_chk (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// events and register port
	input wire efim_pkg::efim_events_type cond_in,
	input wire efim_pkg::efim_req_type req,
	// outputs
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic wake_alert_out_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence wake_edge_s;
		$rose(cond_in.wake) && clk_en;
	endsequence
	sequence flag_taken_s;
		clk_en;
	endsequence
	sequence mask_read_s;
		clk_en && req.rd && req.addr == 8'h01;
	endsequence
	read_ans_a: assert property (clk_en && req.rd |=> rvalid) else $error("rvalid");
	rvalid_once_a: assert property (clk_en && !req.rd |=> !rvalid) else $error("rvalid");
	gap_bit_a: assert property (rvalid |-> !rdata[5]) else $error("bit 5");
	mask_gap_a: assert property (mask_read_s |=> !rdata[7]) else $error("bit 7");
	wake_pin_a: assert property (wake_edge_s ##1 flag_taken_s
		|=> !wake_alert_out_n) else $error("wake");
	reset_out_a: assert property (disable iff (1'b0) rst
		|=> wake_alert_out_n && !rvalid && rdata == 8'h00) else $error("reset");
endmodule // efim_chk
bind efim_top efim_chk efim_chk_inst (.*);

// [bench/efim_host.sv]
// Purpose: register host of the event flag block
// Assumes: the block samples on the rising edge
// Notes: strobes last one cycle and are changed on the falling edge
`timescale 1ns/10ps
module efim_host (
	// register port
	input wire logic ref_clk,
	output efim_pkg::efim_req_type req
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(negedge ref_clk) req = '{!w, w, a, d};
		@(negedge ref_clk) req = '0;
	endtask
endmodule // efim_host

// [bench/tb_top.sv]
// Purpose: efim_top bench
// Assumes: inputs change on the falling edge
// Notes: wake pulse is 20k cycles
`timescale 1ns/10ps
module tb_top;
	logic ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, rvalid, wake_alert_out_n;
	logic [7:0] rdata;
	efim_pkg::efim_events_type cond_in = '0;
	efim_pkg::efim_req_type req;
	int n_fail = 0, tests_run = 0;
	// row: event, mask, expected pin
	logic [14:0] tab [3] = '{{6'h1e, 9'h0}, {6'h20, 9'h0}, {6'h1f, 9'h1ff}};
	always #5 ref_clk = ~ref_clk;
	efim_top efim_top_inst (.*);
	efim_host efim_host_inst (.ref_clk, .req);
	task automatic chk(input logic [7:0] g, e);
		tests_run++;
		n_fail += g !== e;
		if (g !== e) $display("MISMATCH %0t %h/%h", $time, g, e);
	endtask
	task automatic rd(input logic [7:0] a, e);
		efim_host_inst.xfer(1'h0, a, 8'h00);
		chk(rvalid, 1'h1);
		chk(rdata, e);
	endtask
	task automatic stop_test(input int hung);
		n_fail += hung;
		$display("%0d of %0d failed", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial #400us stop_test(1);
	initial
	begin
		#20 rst = 1'h0;
		rd(8'h01, 8'h00);
		foreach (tab[i])
		begin
			efim_host_inst.xfer(1'h1, 8'h01, tab[i][8:1]);
			cond_in = tab[i][14:9];
			#30;
			chk(wake_alert_out_n, tab[i][0]);
			cond_in = '0;
			rd(8'h00, {1'h0, tab[i][14], 1'h0, tab[i][13:9]});
			#10;
			chk(wake_alert_out_n, 1'h1);
		end
		rd(8'h01, 8'h5f);
		// mid-run reset puts the mask back to zero and keeps the pin released
		@(negedge ref_clk) rst = 1'h1;
		#20 rst = 1'h0;
		chk(wake_alert_out_n, 1'h1);
		rd(8'h01, 8'h00);
		efim_host_inst.xfer(1'h1, 8'h01, 8'h40);
		// a condition that rises while the enable is low is seen once it returns
		clk_en = 1'h0;
		cond_in.therm_warn = 1'h1;
		#30;
		chk(wake_alert_out_n, 1'h1);
		clk_en = 1'h1;
		#30;
		chk(wake_alert_out_n, 1'h0);
		cond_in = '0;
		rd(8'h00, 8'h01);
		#10;
		chk(wake_alert_out_n, 1'h1);
		cond_in.wake = 1'h1;
		#100us;
		chk(wake_alert_out_n, 1'h0);
		#99.99us;
		chk(wake_alert_out_n, 1'h0);
		#0.11us;
		chk(wake_alert_out_n, 1'h1);
		rd(8'h00, 8'h40);
		stop_test(0);
	end
endmodule // tb_top
